// ### core/cas_agen.sv
// Effective address former for zero page, absolute indexed and indirect modes
`timescale 1ns/100ps
`include "cas_regs.svh"

module cas_agen (
   // Mode and operands
   input  wire cas_pkg::cas_mode_t mode_i,
   input  wire logic [7:0]         base_lo_i,
   input  wire logic [7:0]         base_hi_i,
   input  wire logic [7:0]         x_i,
   input  wire logic [7:0]         y_i,
   // Results
   output logic [7:0]              zp_ptr_o,
   output logic [7:0]              zp_ptr_hi_o,
   output logic [15:0]             ea_o
);
   import cas_pkg::*;

   logic [7:0] index;

   // Index picked by mode; indirect indexed only ever uses Y
   always_comb begin
      case (mode_i)
         CAS_M_ABSX: index = x_i;
         CAS_M_ABSY: index = y_i;
         CAS_M_INDY: index = y_i;
         default:    index = 8'h00;
      endcase
   end

   // Pointer location in page zero; the 8-bit sum wraps without a carry out
   always_comb begin
      if (mode_i == CAS_M_XIND) begin
         zp_ptr_o = 8'(base_lo_i + x_i);
      end else begin
         zp_ptr_o = base_lo_i;
      end
      zp_ptr_hi_o = 8'(zp_ptr_o + 8'h01);
   end

   // Full 16-bit sum; a carry crosses into the next page
   always_comb begin
      if (mode_i == CAS_M_ZP) begin
         ea_o = {`CAS_ZERO_PAGE, base_lo_i};
      end else begin
         ea_o = 16'({base_hi_i, base_lo_i} + {8'h00, index});
      end
   end

endmodule // cas_agen

// ### core/cas_core.sv
// Core sequencer: operand fetch, address modes, page-one stack and zero-flag branches
`timescale 1ns/100ps
`include "cas_regs.svh"

module cas_core #(
   parameter int unsigned DATA_W   = 8,
   parameter logic [15:0] RESET_PC = `CAS_PC_RESET
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Memory port, asynchronous read of mem_addr_o
   input  wire logic [7:0]  mem_rdata_i,
   output logic [15:0]      mem_addr_o,
   output logic [7:0]       mem_wdata_o,
   output logic             mem_we_o,
   output logic             mem_re_o,
   // Observation of processor state
   output logic             sync_o,
   output logic [15:0]      pc_o,
   output logic [7:0]       acc_o,
   output logic [7:0]       x_o,
   output logic [7:0]       y_o,
   output logic [7:0]       sp_o,
   output logic [7:0]       status_o
);
   import cas_pkg::*;

   // The datapath is byte wide by construction
   if (DATA_W != 8) begin : g_width_check
      $error("cas_core supports DATA_W of 8 only");
   end

   // Architectural registers
   logic [15:0] pc_reg,     pc_next;
   logic [7:0]  acc_reg,    acc_next;
   logic [7:0]  x_reg,      x_next;
   logic [7:0]  y_reg,      y_next;
   logic [7:0]  sp_reg,     sp_next;
   logic [7:0]  status_reg, status_next;
   // Sequencer and operand holding
   cas_state_t  state_reg,  state_next;
   cas_instr_t  instr_reg,  instr_next;
   logic [7:0]  lo_reg,     lo_next;
   logic [7:0]  ptr_reg,    ptr_next;
   // Registered bus drive
   logic [15:0] mem_addr_reg,  mem_addr_next;
   logic [7:0]  mem_wdata_reg, mem_wdata_next;
   logic        mem_we_reg,    mem_we_next;
   logic        mem_re_reg,    mem_re_next;

   // Address former outputs and helpers
   cas_instr_t  fetched;
   cas_mode_t   agen_mode;
   logic [7:0]  agen_lo;
   logic [7:0]  agen_hi;
   logic [7:0]  zp_ptr;
   logic [7:0]  zp_ptr_hi;
   logic [15:0] ea;
   logic [15:0] pc_inc;
   logic [15:0] br_target;
   logic        br_take;

   // Stack address: the pointer is only the low byte
   function automatic logic [15:0] stack_addr(input logic [7:0] sp);
      return {`CAS_STACK_PAGE, sp};
   endfunction

   // Zero flag folded into a status byte
   function automatic logic [7:0] with_zero(input logic [7:0] st, input logic [7:0] res);
      logic [7:0] r;
      r = st;
      r[`CAS_ZERO_BIT] = (res == 8'h00);
      return r;
   endfunction

   assign fetched = cas_decode(mem_rdata_i);
   assign pc_inc  = 16'(pc_reg + 16'h0001);

   // Operand selection for the address former; the live byte is the high half in OPHI and PTRHI
   always_comb begin
      agen_mode = instr_reg.mode;
      agen_lo   = lo_reg;
      agen_hi   = mem_rdata_i;
      if (state_reg == CAS_S_OPLO) begin
         agen_lo = mem_rdata_i;
         agen_hi = 8'h00;
      end
      if (state_reg == CAS_S_PTRHI && instr_reg.mode == CAS_M_XIND) begin
         agen_mode = CAS_M_ABS;
      end
   end

   cas_agen u_agen (
      .mode_i      (agen_mode),
      .base_lo_i   (agen_lo),
      .base_hi_i   (agen_hi),
      .x_i         (x_reg),
      .y_i         (y_reg),
      .zp_ptr_o    (zp_ptr),
      .zp_ptr_hi_o (zp_ptr_hi),
      .ea_o        (ea)
   );

   // Branch decision looks only at the live status byte, never at a saved result
   always_comb begin
      if (instr_reg.br_on_set) begin
         br_take = status_reg[`CAS_ZERO_BIT];
      end else begin
         br_take = !status_reg[`CAS_ZERO_BIT];
      end
      // Offset counts from the byte after the offset, sign extended
      br_target = 16'(pc_inc + {{8{mem_rdata_i[7]}}, mem_rdata_i});
   end

   // Sequencer: each state consumes the byte read at the address set on entry
   always_comb begin
      state_next     = state_reg;
      instr_next     = instr_reg;
      pc_next        = pc_reg;
      acc_next       = acc_reg;
      x_next         = x_reg;
      y_next         = y_reg;
      sp_next        = sp_reg;
      status_next    = status_reg;
      lo_next        = lo_reg;
      ptr_next       = ptr_reg;
      mem_addr_next  = mem_addr_reg;
      mem_wdata_next = mem_wdata_reg;
      mem_we_next    = 1'b0;
      mem_re_next    = 1'b1;
      case (state_reg)
         CAS_S_FETCH: begin
            instr_next    = fetched;
            pc_next       = pc_inc;
            mem_addr_next = pc_inc;
            case (fetched.kind)
               CAS_K_PUSH: begin
                  // Implied: no operand byte, write goes at the free slot
                  mem_addr_next  = stack_addr(sp_reg);
                  mem_wdata_next = (fetched.sel == CAS_R_P) ? status_reg : acc_reg;
                  mem_we_next    = 1'b1;
                  mem_re_next    = 1'b0;
                  state_next     = CAS_S_STACK;
               end
               CAS_K_PULL: begin
                  // Pointer moves first, then the read uses the new value
                  sp_next       = 8'(sp_reg + 8'h01);
                  mem_addr_next = stack_addr(8'(sp_reg + 8'h01));
                  state_next    = CAS_S_STACK;
               end
               CAS_K_LOAD, CAS_K_BRANCH: begin
                  state_next = (fetched.mode == CAS_M_IMM) ? CAS_S_IMM : CAS_S_OPLO;
               end
               CAS_K_STORE: begin
                  state_next = CAS_S_OPLO;
               end
               default: begin
                  state_next = CAS_S_FETCH;
               end
            endcase
         end
         CAS_S_IMM: begin
            pc_next       = pc_inc;
            mem_addr_next = pc_inc;
            state_next    = CAS_S_FETCH;
            if (instr_reg.kind == CAS_K_BRANCH) begin
               // Not taken: fall through to the next opcode, nothing else moves
               if (br_take) begin
                  pc_next       = br_target;
                  mem_addr_next = br_target;
               end
            end else begin
               case (instr_reg.sel)
                  CAS_R_X: x_next   = mem_rdata_i;
                  CAS_R_Y: y_next   = mem_rdata_i;
                  default: acc_next = mem_rdata_i;
               endcase
               status_next = with_zero(status_reg, mem_rdata_i);
            end
         end
         CAS_S_OPLO: begin
            // Low byte of any address operand arrives first
            lo_next = mem_rdata_i;
            pc_next = pc_inc;
            case (instr_reg.mode)
               CAS_M_ZP: begin
                  mem_addr_next = ea;
                  state_next    = CAS_S_EXEC;
               end
               CAS_M_INDY, CAS_M_XIND: begin
                  ptr_next      = zp_ptr;
                  mem_addr_next = {`CAS_ZERO_PAGE, zp_ptr};
                  state_next    = CAS_S_PTRLO;
               end
               default: begin
                  mem_addr_next = pc_inc;
                  state_next    = CAS_S_OPHI;
               end
            endcase
         end
         CAS_S_OPHI: begin
            // High byte completes the base; the index rides on it
            pc_next       = pc_inc;
            mem_addr_next = ea;
            state_next    = CAS_S_EXEC;
         end
         CAS_S_PTRLO: begin
            lo_next       = mem_rdata_i;
            mem_addr_next = {`CAS_ZERO_PAGE, 8'(ptr_reg + 8'h01)};
            state_next    = CAS_S_PTRHI;
         end
         CAS_S_PTRHI: begin
            mem_addr_next = ea;
            state_next    = CAS_S_EXEC;
         end
         CAS_S_EXEC: begin
            // Loads were reading the operand; stores were writing it
            if (instr_reg.kind == CAS_K_LOAD) begin
               acc_next    = mem_rdata_i;
               status_next = with_zero(status_reg, mem_rdata_i);
            end
            mem_addr_next = pc_reg;
            state_next    = CAS_S_FETCH;
         end
         CAS_S_STACK: begin
            if (instr_reg.kind == CAS_K_PUSH) begin
               sp_next = 8'(sp_reg - 8'h01);
            end else if (instr_reg.sel == CAS_R_P) begin
               status_next = mem_rdata_i;
            end else begin
               acc_next    = mem_rdata_i;
               status_next = with_zero(status_reg, mem_rdata_i);
            end
            mem_addr_next = pc_reg;
            state_next    = CAS_S_FETCH;
         end
         default: begin
            mem_addr_next = pc_reg;
            state_next    = CAS_S_FETCH;
         end
      endcase
      // Entering EXEC for a store drives the accumulator out
      if (state_next == CAS_S_EXEC && instr_reg.kind == CAS_K_STORE) begin
         mem_wdata_next = acc_reg;
         mem_we_next    = 1'b1;
         mem_re_next    = 1'b0;
      end
   end

   // Sequencer state and decoded instruction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= CAS_S_FETCH;
         instr_reg <= '{kind: CAS_K_NOP, mode: CAS_M_IMP, sel: CAS_R_A, br_on_set: 1'b0};
         lo_reg    <= 8'h00;
         ptr_reg   <= 8'h00;
      end else begin
         state_reg <= state_next;
         instr_reg <= instr_next;
         lo_reg    <= lo_next;
         ptr_reg   <= ptr_next;
      end
   end

   // Program counter and working registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_reg  <= RESET_PC;
         acc_reg <= 8'h00;
         x_reg   <= 8'h00;
         y_reg   <= 8'h00;
      end else begin
         pc_reg  <= pc_next;
         acc_reg <= acc_next;
         x_reg   <= x_next;
         y_reg   <= y_next;
      end
   end

   // Stack pointer and status; the pointer starts at the top of page one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_reg     <= `CAS_SP_RESET;
         status_reg <= `CAS_STATUS_RESET;
      end else begin
         sp_reg     <= sp_next;
         status_reg <= status_next;
      end
   end

   // Bus drive is registered so the memory sees clean address and strobes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_addr_reg  <= RESET_PC;
         mem_wdata_reg <= 8'h00;
         mem_we_reg    <= 1'b0;
         mem_re_reg    <= 1'b1;
      end else begin
         mem_addr_reg  <= mem_addr_next;
         mem_wdata_reg <= mem_wdata_next;
         mem_we_reg    <= mem_we_next;
         mem_re_reg    <= mem_re_next;
      end
   end

   // Outputs
   assign mem_addr_o  = mem_addr_reg;
   assign mem_wdata_o = mem_wdata_reg;
   assign mem_we_o    = mem_we_reg;
   assign mem_re_o    = mem_re_reg;
   assign sync_o      = (state_reg == CAS_S_FETCH);
   assign pc_o        = pc_reg;
   assign acc_o       = acc_reg;
   assign x_o         = x_reg;
   assign y_o         = y_reg;
   assign sp_o        = sp_reg;
   assign status_o    = status_reg;

endmodule // cas_core

// ### shared/cas_pkg.sv
// Types and opcode decoding shared by the address, stack and branch core
`include "cas_regs.svh"

package cas_pkg;

   // Instruction classes
   typedef enum logic [2:0] {
      CAS_K_NOP, CAS_K_LOAD, CAS_K_STORE, CAS_K_PUSH, CAS_K_PULL, CAS_K_BRANCH
   } cas_kind_t;

   // Addressing modes
   typedef enum logic [2:0] {
      CAS_M_IMP, CAS_M_IMM, CAS_M_ZP, CAS_M_ABS, CAS_M_ABSX, CAS_M_ABSY, CAS_M_INDY, CAS_M_XIND
   } cas_mode_t;

   // Register that an instruction reads or fills
   typedef enum logic [1:0] {CAS_R_A, CAS_R_X, CAS_R_Y, CAS_R_P} cas_reg_sel_t;

   // One decoded instruction
   typedef struct packed {
      cas_kind_t    kind;
      cas_mode_t    mode;
      cas_reg_sel_t sel;
      logic         br_on_set;
   } cas_instr_t;

   // Sequencer states, one-hot
   typedef enum logic [7:0] {
      CAS_S_FETCH  = 8'h01,
      CAS_S_IMM    = 8'h02,
      CAS_S_OPLO   = 8'h04,
      CAS_S_OPHI   = 8'h08,
      CAS_S_PTRLO  = 8'h10,
      CAS_S_PTRHI  = 8'h20,
      CAS_S_EXEC   = 8'h40,
      CAS_S_STACK  = 8'h80
   } cas_state_t;

   // Opcode byte to decoded form; anything unknown is a one-byte no-op
   function automatic cas_instr_t cas_decode(input logic [7:0] opc);
      cas_instr_t d;
      d = '{kind: CAS_K_NOP, mode: CAS_M_IMP, sel: CAS_R_A, br_on_set: 1'b0};
      case (opc)
         `CAS_OP_LOAD_IMM:    d = '{CAS_K_LOAD,   CAS_M_IMM,  CAS_R_A, 1'b0};
         `CAS_OP_LOAD_ZP:     d = '{CAS_K_LOAD,   CAS_M_ZP,   CAS_R_A, 1'b0};
         `CAS_OP_LOAD_ABS:    d = '{CAS_K_LOAD,   CAS_M_ABS,  CAS_R_A, 1'b0};
         `CAS_OP_LOAD_ABSX:   d = '{CAS_K_LOAD,   CAS_M_ABSX, CAS_R_A, 1'b0};
         `CAS_OP_LOAD_ABSY:   d = '{CAS_K_LOAD,   CAS_M_ABSY, CAS_R_A, 1'b0};
         `CAS_OP_LOAD_INDY:   d = '{CAS_K_LOAD,   CAS_M_INDY, CAS_R_A, 1'b0};
         `CAS_OP_LOAD_XIND:   d = '{CAS_K_LOAD,   CAS_M_XIND, CAS_R_A, 1'b0};
         `CAS_OP_STORE_ZP:    d = '{CAS_K_STORE,  CAS_M_ZP,   CAS_R_A, 1'b0};
         `CAS_OP_STORE_ABS:   d = '{CAS_K_STORE,  CAS_M_ABS,  CAS_R_A, 1'b0};
         `CAS_OP_STORE_ABSX:  d = '{CAS_K_STORE,  CAS_M_ABSX, CAS_R_A, 1'b0};
         `CAS_OP_STORE_ABSY:  d = '{CAS_K_STORE,  CAS_M_ABSY, CAS_R_A, 1'b0};
         `CAS_OP_STORE_INDY:  d = '{CAS_K_STORE,  CAS_M_INDY, CAS_R_A, 1'b0};
         `CAS_OP_STORE_XIND:  d = '{CAS_K_STORE,  CAS_M_XIND, CAS_R_A, 1'b0};
         `CAS_OP_LOAD_X_IMM:  d = '{CAS_K_LOAD,   CAS_M_IMM,  CAS_R_X, 1'b0};
         `CAS_OP_LOAD_Y_IMM:  d = '{CAS_K_LOAD,   CAS_M_IMM,  CAS_R_Y, 1'b0};
         `CAS_OP_PUSH_ACC:    d = '{CAS_K_PUSH,   CAS_M_IMP,  CAS_R_A, 1'b0};
         `CAS_OP_PULL_ACC:    d = '{CAS_K_PULL,   CAS_M_IMP,  CAS_R_A, 1'b0};
         `CAS_OP_PUSH_STATUS: d = '{CAS_K_PUSH,   CAS_M_IMP,  CAS_R_P, 1'b0};
         `CAS_OP_PULL_STATUS: d = '{CAS_K_PULL,   CAS_M_IMP,  CAS_R_P, 1'b0};
         `CAS_OP_BR_ZERO:     d = '{CAS_K_BRANCH, CAS_M_IMM,  CAS_R_P, 1'b1};
         `CAS_OP_BR_NONZERO:  d = '{CAS_K_BRANCH, CAS_M_IMM,  CAS_R_P, 1'b0};
         default:             d = '{CAS_K_NOP,    CAS_M_IMP,  CAS_R_A, 1'b0};
      endcase
      return d;
   endfunction

endpackage

// ### shared/cas_regs.svh
// Constants for the address, stack and branch core: opcodes, reset values, layout
`ifndef CAS_REGS_SVH
`define CAS_REGS_SVH

// Reset values
`define CAS_PC_RESET        16'h0000
`define CAS_SP_RESET        8'hff
`define CAS_STATUS_RESET    8'h00

// Page numbers that pin the upper address byte
`define CAS_ZERO_PAGE       8'h00
`define CAS_STACK_PAGE      8'h01

// Status register field position
`define CAS_ZERO_BIT        1

// Opcodes of load_accumulator
`define CAS_OP_LOAD_IMM     8'ha9
`define CAS_OP_LOAD_ZP      8'ha1
`define CAS_OP_LOAD_ABS     8'had
`define CAS_OP_LOAD_ABSX    8'ha2
`define CAS_OP_LOAD_ABSY    8'ha3
`define CAS_OP_LOAD_INDY    8'ha4
`define CAS_OP_LOAD_XIND    8'ha6
// Opcodes of store_accumulator
`define CAS_OP_STORE_ZP     8'h81
`define CAS_OP_STORE_ABS    8'h8d
`define CAS_OP_STORE_ABSX   8'h82
`define CAS_OP_STORE_ABSY   8'h83
`define CAS_OP_STORE_INDY   8'h84
`define CAS_OP_STORE_XIND   8'h86
// Index loads, immediate only
`define CAS_OP_LOAD_X_IMM   8'hc1
`define CAS_OP_LOAD_Y_IMM   8'hc2
// Implied stack instructions
`define CAS_OP_PUSH_ACC     8'h40
`define CAS_OP_PULL_ACC     8'h41
`define CAS_OP_PUSH_STATUS  8'h42
`define CAS_OP_PULL_STATUS  8'h43
// Conditional branches
`define CAS_OP_BR_ZERO      8'h50
`define CAS_OP_BR_NONZERO   8'h51

`endif

// ### verification/cas_core_props.sv
// Checker for the address, stack and branch core, bound to its ports
`timescale 1ns/100ps
`include "cas_regs.svh"

module cas_core_props #(
   parameter int unsigned DATA_W   = 8,
   parameter logic [15:0] RESET_PC = 16'h0000
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Memory port
   input wire logic [7:0]  mem_rdata_i,
   input wire logic [15:0] mem_addr_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic        mem_we_o,
   input wire logic        mem_re_o,
   // Processor state
   input wire logic        sync_o,
   input wire logic [15:0] pc_o,
   input wire logic [7:0]  acc_o,
   input wire logic [7:0]  x_o,
   input wire logic [7:0]  y_o,
   input wire logic [7:0]  sp_o,
   input wire logic [7:0]  status_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Opcode seen in a fetch cycle
   sequence op_s(logic [7:0] op);
      sync_o && mem_rdata_i == op;
   endsequence

   // Branch target worked from the fetch address two cycles back
   property br_p(logic [7:0] op, logic on_set);
      op_s(op) |=> ##1 sync_o && mem_addr_o == (($past(status_o[1], 2) == on_set)
         ? $past(mem_addr_o, 2) + 16'h0002 + {{8{$past(mem_rdata_i[7])}}, $past(mem_rdata_i)}
         : $past(mem_addr_o, 2) + 16'h0002);
   endproperty

   push_acc_write_a: assert property (op_s(`CAS_OP_PUSH_ACC) |=> mem_we_o
      && mem_addr_o == {8'h01, $past(sp_o)} && mem_wdata_o == $past(acc_o)
      ##1 sp_o == $past(sp_o, 2) - 8'h01) else $error("push write or pointer step wrong");
   pull_acc_read_a: assert property (op_s(`CAS_OP_PULL_ACC) |=> sp_o == $past(sp_o) + 8'h01
      && mem_addr_o == {8'h01, sp_o} && !mem_we_o ##1 acc_o == $past(mem_rdata_i))
      else $error("pull order or data wrong");
   push_status_len_a: assert property (op_s(`CAS_OP_PUSH_STATUS) |=> mem_we_o
      && mem_wdata_o == $past(status_o) ##1 sync_o && mem_addr_o == $past(mem_addr_o, 2) + 16'h0001)
      else $error("status push wrong or not one byte");
   zp_store_page_a: assert property (op_s(`CAS_OP_STORE_ZP) |=> ##1 mem_we_o
      && mem_addr_o == {8'h00, $past(mem_rdata_i)} && mem_wdata_o == acc_o)
      else $error("zero page store address wrong");
   zero_flag_load_a: assert property (op_s(`CAS_OP_LOAD_IMM) |=> ##1
      status_o[1] == ($past(mem_rdata_i) == 8'h00)) else $error("zero flag wrong after load");
   absx_store_addr_a: assert property (op_s(`CAS_OP_STORE_ABSX) |=> ##2 mem_we_o
      && mem_addr_o == {$past(mem_rdata_i), $past(mem_rdata_i, 2)} + {8'h00, x_o})
      else $error("indexed store address wrong");
   branch_zero_a: assert property (br_p(`CAS_OP_BR_ZERO, 1'b1))
      else $error("branch on zero target wrong");
   branch_nonzero_a: assert property (br_p(`CAS_OP_BR_NONZERO, 1'b0))
      else $error("branch on nonzero target wrong");
   write_single_a: assert property (mem_we_o |=> !mem_we_o)
      else $error("write strobe longer than one cycle");
   read_flag_a: assert property (mem_re_o == !mem_we_o)
      else $error("read flag not the inverse of write strobe");
   index_load_a: assert property (op_s(`CAS_OP_LOAD_X_IMM) |=> ##1 x_o == $past(mem_rdata_i))
      else $error("index load value wrong");

   // Main scenarios reached
   cover property (op_s(`CAS_OP_PUSH_ACC));
   cover property (op_s(`CAS_OP_PULL_STATUS));
   cover property (sync_o && mem_rdata_i == `CAS_OP_BR_ZERO && status_o[1]);
endmodule // cas_core_props

bind cas_core cas_core_props #(.DATA_W(DATA_W), .RESET_PC(RESET_PC)) cas_core_props_i (
   .clk_i(clk_i), .rst_i(rst_i), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .sync_o(sync_o),
   .pc_o(pc_o), .acc_o(acc_o), .x_o(x_o), .y_o(y_o), .sp_o(sp_o), .status_o(status_o));

// ### verification/cas_core_tb.sv
// Bench for the core: program image, write scoreboard and verdict
`timescale 1ns/100ps
`include "cas_regs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module cas_core_tb;
   localparam logic [15:0] START = 16'h0200;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  rdata, wdata, acc, x, y, sp, status;
   logic [15:0] addr, pc_o;
   logic        we, sync;
   logic [15:0] pc;
   logic [31:0] seed = 32'h74bcce44;
   logic [7:0]  a1, xv, yv, plo, phi;
   logic [23:0] expq[$];
   logic [23:0] exp_w;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;

   cas_core #(.RESET_PC(START)) cas_core_i (.clk_i(clk_i), .rst_i(rst_i), .mem_rdata_i(rdata),
      .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_we_o(we), .mem_re_o(), .sync_o(sync),
      .pc_o(pc_o), .acc_o(acc), .x_o(x), .y_o(y), .sp_o(sp), .status_o(status));
   cas_mem cas_mem_i (.clk_i(clk_i), .addr_i(addr), .wdata_i(wdata), .we_i(we), .rdata_o(rdata));

   always #10 clk_i = ~clk_i;

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Shift register stepped once per draw; the low byte is the random value
   function automatic logic [7:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   task automatic put(input logic [7:0] b);
      cas_mem_i.mem[pc] = b;
      pc++;
   endtask

   // Address operands go low byte first
   task automatic put16(input logic [7:0] op, input logic [15:0] a);
      put(op);
      put(a[7:0]);
      put(a[15:8]);
   endtask

   // Expected memory write, in program order
   task automatic exp_wr(input logic [15:0] a, input logic [7:0] d);
      expq.push_back({a, d});
   endtask

   // Every write strobe takes the oldest note; a write with none pending is stray
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         results();
      end else if (!rst_i && we) begin
         if (expq.size() == 0) begin
            mismatches++;
            $display("mismatch at %0t: stray write at %h", $time, addr);
         end else begin
            exp_w = expq.pop_front();
            `CHK({addr, wdata}, exp_w)
         end
      end
   end

   initial begin
      // Let the memory model fill its cells first, or the image is wiped
      #1;
      a1 = nxt();
      xv = nxt();
      yv = nxt();
      plo = nxt();
      phi = nxt();
      a1[0] = 1'b1;
      xv[7] = 1'b1; // Pointer sum always wraps in page zero
      plo[7] = 1'b1; // Pointers stay clear of program and stack
      phi[7] = 1'b1;
      cas_mem_i.mem[16'h00ff] = plo;
      cas_mem_i.mem[16'h0000] = phi;
      cas_mem_i.mem[16'h0040] = phi;
      cas_mem_i.mem[16'h0041] = plo;
      pc = START;
      put(`CAS_OP_LOAD_IMM); put(a1);
      put16(`CAS_OP_STORE_ABS, 16'h0400); exp_wr(16'h0400, a1);
      put(`CAS_OP_LOAD_X_IMM); put(xv);
      put(`CAS_OP_LOAD_Y_IMM); put(yv);
      put16(`CAS_OP_STORE_ABSX, 16'h12f0); exp_wr(16'h12f0 + {8'h00, xv}, a1);
      put16(`CAS_OP_STORE_ABSY, 16'h34ff); exp_wr(16'h34ff + {8'h00, yv}, a1);
      put(`CAS_OP_STORE_ZP); put(8'h80); exp_wr(16'h0080, a1);
      put(`CAS_OP_STORE_INDY); put(8'hff); exp_wr({phi, plo} + {8'h00, yv}, a1);
      put(`CAS_OP_STORE_XIND); put(8'h40 - xv); exp_wr({plo, phi}, a1);
      // Read each byte back by its load mode; a wrong address returns other data
      put(`CAS_OP_LOAD_ZP); put(8'h80); put16(`CAS_OP_STORE_ABS, 16'h0503); exp_wr(16'h0503, a1);
      put16(`CAS_OP_LOAD_ABSX, 16'h12f0); put16(`CAS_OP_STORE_ABS, 16'h0504); exp_wr(16'h0504, a1);
      put16(`CAS_OP_LOAD_ABSY, 16'h34ff); put16(`CAS_OP_STORE_ABS, 16'h0505); exp_wr(16'h0505, a1);
      put(`CAS_OP_LOAD_INDY); put(8'hff); put16(`CAS_OP_STORE_ABS, 16'h0506); exp_wr(16'h0506, a1);
      put(`CAS_OP_LOAD_XIND); put(8'h40 - xv); put16(`CAS_OP_STORE_ABS, 16'h0507); exp_wr(16'h0507, a1);
      put16(`CAS_OP_LOAD_ABS, 16'h0400); put16(`CAS_OP_STORE_ABS, 16'h0508); exp_wr(16'h0508, a1);
      // Stack walks down from the top of page one
      put(`CAS_OP_PUSH_ACC); exp_wr(16'h01ff, a1);
      put(`CAS_OP_PUSH_STATUS); exp_wr(16'h01fe, 8'h00);
      put(`CAS_OP_LOAD_IMM); put(8'h00);
      put(`CAS_OP_PUSH_STATUS); exp_wr(16'h01fd, 8'h02);
      // Acc nonzero, yet the pulled flag must steer the branch
      put(`CAS_OP_LOAD_IMM); put(a1);
      put(`CAS_OP_PULL_STATUS);
      put(`CAS_OP_BR_ZERO); put(8'h7f);
      repeat (127) put(`CAS_OP_PUSH_ACC);
      put(`CAS_OP_BR_NONZERO); put(8'h03);
      put16(`CAS_OP_STORE_ABS, 16'h0500); exp_wr(16'h0500, a1);
      put(`CAS_OP_PULL_STATUS);
      put(`CAS_OP_BR_ZERO); put(8'h03);
      put16(`CAS_OP_STORE_ABS, 16'h0501); exp_wr(16'h0501, a1);
      put(`CAS_OP_LOAD_IMM); put(8'h00);
      put(`CAS_OP_PULL_ACC);
      put16(`CAS_OP_STORE_ABS, 16'h0502); exp_wr(16'h0502, a1);
      put(`CAS_OP_BR_NONZERO); put(8'hfe); // Park on itself
      repeat (6) @(negedge clk_i);
      `CHK(sp, 8'hff)
      `CHK(pc_o, START)
      `CHK(status, 8'h00)
      rst_i = 1'b0;
      for (int i = 0; i < 1000 && expq.size() != 0; i++) @(negedge clk_i);
      repeat (20) @(negedge clk_i);
      `CHK(expq.size(), 0)
      `CHK(sp, 8'hff)
      `CHK(acc, a1)
      `CHK(x, xv)
      `CHK(y, yv)
      `CHK(status[1], 1'b0)
      results();
   end
endmodule // cas_core_tb

// ### verification/cas_mem.sv
// Byte-wide system memory model: combinational read, write on the rising edge
`timescale 1ns/100ps

module cas_mem (
   // Clock
   input  wire logic        clk_i,
   // Access
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        we_i,
   output logic [7:0]       rdata_o
);
   logic [7:0] mem [0:65535];

   // Unused cells hold push opcodes so stray execution shows up as extra writes
   initial begin
      foreach (mem[i]) mem[i] = 8'h40;
   end

   // Read has no latency, as the core expects
   assign rdata_o = mem[addr_i];

   // Write lands at the edge ending the strobe cycle
   always @(posedge clk_i) begin
      if (we_i) mem[addr_i] <= wdata_i;
   end
endmodule // cas_mem
